// *** inc/io_pkg.sv ***
package io_pkg;
   // ************************************
   // sizes of the images
   // ************************************
   localparam int DI_BASE = 8;
   localparam int DI_EXP = 16;
   localparam int DO_BASE = 4;
   localparam int DO_EXP = 16;
   localparam int AI_NUM = 8;
   localparam int AI_LOCAL = 4;
   localparam int AI_EXP = 4;
   localparam int AQ_NUM = 8;
   localparam int ANA_W = 16;
   localparam int FLAG_NUM = 64;
   localparam int AM_NUM = 64;
   localparam int BLANK_NUM = 64;
   localparam int SHIFT_NUM = 32;
   localparam int KEY_NUM = 4;
   localparam int NI_NUM = 64;
   localparam int NAI_NUM = 32;
   localparam int NQ_NUM = 64;
   localparam int NAQ_NUM = 16;
   localparam int FAST_NUM = 4;
   localparam int FAST_FIRST = 2;
   localparam int FAST_W = 16;
   // ************************************
   // input filter timing
   // ************************************
   localparam int MAINS_DI_NUM = 8;
   localparam int FILT_W = 7;
   localparam logic [6:0] ON_MAINS_MS = 7'h19;
   localparam logic [6:0] OFF_MAINS_MS = 7'h14;
   localparam logic [6:0] ON_STD_MS = 7'h05;
   localparam logic [6:0] OFF_STD_MS = 7'h05;
   localparam logic [6:0] RETAIN_MS = 7'h64;
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_NS;
   // ************************************
   // special flag positions (zero based)
   // ************************************
   localparam int STARTUP_IDX = 7;
   localparam int WHITE_BASE_IDX = 24;
   localparam int WHITE_PANEL_IDX = 25;
   localparam int CHARSET_IDX = 26;
   localparam int AMBER_BASE_IDX = 27;
   localparam int RED_BASE_IDX = 28;
   localparam int AMBER_PANEL_IDX = 29;
   localparam int RED_PANEL_IDX = 30;
   localparam int ADC_TWO = 2;
   // ************************************
   // register map
   // ************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_DI = 4'h2;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int CTL_MAINS = 0;
   localparam int CTL_DC = 1;
   localparam int CTL_SLAVE = 2;
   localparam int CTL_ADC4 = 3;
   localparam int CTL_CSET = 4;
   localparam int CTL_CSET_PROG = 5;
   localparam int CTL_NET_PROG = 6;
   localparam int ST_FIRST = 0;
   localparam int ST_RUN = 1;
   localparam int ST_DAC_ERR = 2;
   // ************************************
   // types
   // ************************************
   typedef enum logic [1:0] {SRC_FUNC, SRC_MARKER, SRC_DAC, SRC_OTHER} dac_src_t;
   typedef enum logic [1:0] {COL_OFF, COL_WHITE, COL_AMBER, COL_RED} color_t;
   typedef enum {PH_IDLE, PH_FIRST, PH_RUN} phase_t;
endpackage

// *** verilog/io_image_flags.sv ***
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
// What this block does
// RULE_01: mains relay variant filters inputs one to eight with 25 ms on, 20 ms off.
// RULE_02: other variants filter every digital input 5 ms on and 5 ms off.
// RULE_03: slave mode uses 5 ms on-delay and holds detected signals 100 ms.
// RULE_04: input indices run base terminals first, then expansions in installation order.
// RULE_05: on DC variants inputs three to six also feed fast counters.
// RULE_06: DC inputs 1,2,7,8 stay digital; adc aliases read analog; two or four enabled.
// RULE_07: expansion analog inputs continue after local adc channels; eight channels total.
// RULE_08: twenty digital outputs, base terminals first, then expansion outputs.
// RULE_09: 64 blank outputs drive nothing and are never a source.
// RULE_10: eight dac channels, driven only from analog inputs, markers or dac outputs.
// RULE_11: 64 digital flags and 64 analog markers output their input value.
// RULE_12: startup flag is set in the first program cycle, cleared at its end.
// RULE_13: backlight flags choose white, amber or red for base and panel separately.
// RULE_14: charset flag 0 shows first character set, 1 shows second.
// RULE_15: without charset flag in program, the configured character set is used.
// RULE_16: flag outputs show previous cycle value, constant through the current cycle.
// RULE_17: network may write flags; charset flag acts only when the program holds it.
// RULE_18: shift bits are read-only; only the shift-register function changes them.
// RULE_19: cursor and panel keys act as program inputs in RUN; panel equals base.
// RULE_20: const_one and const_zero give fixed logic levels.
// RULE_21: network image: 64 bit in, 32 word in, 64 bit out, 16 word out.
// RULE_22: with network I/O in the program, only parameter edits are allowed on-unit.
// RULE_23: filtered inputs are sampled into an image once at each cycle start.
module io_image_flags #(
   parameter int MS_CYC = io_pkg::MS_CYC
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [io_pkg::ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // program cycle and device modes
   input wire logic cycle_tick_in,
   input wire logic run_mode_in,
   // field pins
   input wire logic [io_pkg::DI_BASE-1:0] base_di_in,
   input wire logic [io_pkg::DI_EXP-1:0] exp_di_in,
   input wire logic [3*io_pkg::KEY_NUM-1:0] key_pin_in,
   input wire logic [io_pkg::AI_LOCAL*io_pkg::ANA_W-1:0] adc_local_in,
   input wire logic [io_pkg::AI_EXP*io_pkg::ANA_W-1:0] adc_exp_in,
   // program writes
   input wire logic [io_pkg::DO_BASE+io_pkg::DO_EXP-1:0] prog_do_in,
   input wire logic [io_pkg::FLAG_NUM-1:0] prog_flag_wr_in,
   input wire logic [io_pkg::FLAG_NUM-1:0] prog_flag_val_in,
   input wire logic am_wr_in,
   input wire logic [5:0] am_idx_in,
   input wire logic [io_pkg::ANA_W-1:0] am_wdata_in,
   input wire logic [5:0] am_rd_idx_in,
   input wire logic [io_pkg::AQ_NUM-1:0] dac_wr_in,
   input wire logic [1:0] dac_kind_in,
   input wire logic [io_pkg::ANA_W-1:0] dac_wdata_in,
   input wire logic shift_load_in,
   input wire logic [io_pkg::SHIFT_NUM-1:0] shift_val_in,
   input wire logic [io_pkg::NQ_NUM-1:0] prog_nq_in,
   input wire logic [io_pkg::NAQ_NUM*io_pkg::ANA_W-1:0] prog_naq_in,
   // network side
   input wire logic [io_pkg::FLAG_NUM-1:0] net_flag_wr_in,
   input wire logic [io_pkg::FLAG_NUM-1:0] net_flag_val_in,
   input wire logic [io_pkg::NI_NUM-1:0] net_bit_in,
   input wire logic [io_pkg::NAI_NUM*io_pkg::ANA_W-1:0] net_word_in,
   // on-unit editing
   input wire logic edit_req_in,
   input wire logic edit_is_par_in,
   output logic edit_grant_out,
   // images to the program
   output logic [io_pkg::DI_BASE+io_pkg::DI_EXP-1:0] di_image_out,
   output logic [io_pkg::AI_NUM*io_pkg::ANA_W-1:0] adc_image_out,
   output logic [3*io_pkg::KEY_NUM-1:0] key_image_out,
   output logic [io_pkg::FLAG_NUM-1:0] flag_out,
   output logic [io_pkg::ANA_W-1:0] am_rdata_out,
   output logic [io_pkg::SHIFT_NUM-1:0] shift_bits_out,
   output logic [io_pkg::FAST_NUM*io_pkg::FAST_W-1:0] fast_cnt_out,
   output logic const_one_out,
   output logic const_zero_out,
   output logic [io_pkg::NI_NUM-1:0] net_bit_image_out,
   output logic [io_pkg::NAI_NUM*io_pkg::ANA_W-1:0] net_word_image_out,
   // outputs to field and network
   output logic [io_pkg::DO_BASE-1:0] base_do_out,
   output logic [io_pkg::DO_EXP-1:0] exp_do_out,
   output logic [io_pkg::AQ_NUM*io_pkg::ANA_W-1:0] dac_out,
   output logic [io_pkg::NQ_NUM-1:0] net_bit_out,
   output logic [io_pkg::NAQ_NUM*io_pkg::ANA_W-1:0] net_word_out,
   // display
   output logic [1:0] base_color_out,
   output logic [1:0] panel_color_out,
   output logic charset_sel_out
);
   localparam int DI_NUM = io_pkg::DI_BASE + io_pkg::DI_EXP;
   localparam int W = io_pkg::ANA_W;
   localparam int PW = $clog2(MS_CYC);
   localparam int KN = 3 * io_pkg::KEY_NUM;

   logic [31:0] ctrl_r;
   logic dac_err_r;
   logic [PW-1:0] presc_r;
   logic ms_tick;
   logic [DI_NUM-1:0] s1_r, s2_r, s3_r, filt_r, di_image_r;
   logic [KN-1:0] k1_r, k2_r;
   logic [io_pkg::FLAG_NUM-1:0] flag_next_r, flag_img_r, net_mask;
   logic [W-1:0] am_next_r [io_pkg::AM_NUM];
   logic [W-1:0] am_img_r [io_pkg::AM_NUM];
   logic [io_pkg::AI_NUM*W-1:0] adc_map;
   io_pkg::phase_t phase_r;
   logic mains, dc, slave, adc4, cset_prog, net_prog;

   assign mains = ctrl_r[io_pkg::CTL_MAINS];
   assign dc = ctrl_r[io_pkg::CTL_DC];
   assign slave = ctrl_r[io_pkg::CTL_SLAVE];
   assign adc4 = ctrl_r[io_pkg::CTL_ADC4];
   assign cset_prog = ctrl_r[io_pkg::CTL_CSET_PROG];
   assign net_prog = ctrl_r[io_pkg::CTL_NET_PROG];

   // ************************************
   // register port
   // ************************************

   // control word written by the configuration tool
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_r <= io_pkg::CTRL_RST;
      end else if (wr_in && addr_in == io_pkg::REG_CTRL) begin
         ctrl_r <= wdata_in;
      end
   end

   // read data one cycle after the strobe, zero when unmapped
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else if (rd_in) begin
         unique case (addr_in)
            io_pkg::REG_CTRL: rdata_out <= ctrl_r;
            io_pkg::REG_STATUS: rdata_out <= {29'h0000_0000, dac_err_r,
               phase_r == io_pkg::PH_RUN, phase_r == io_pkg::PH_FIRST};
            io_pkg::REG_DI: rdata_out <= {{(32-DI_NUM){1'b0}}, di_image_r};
            default: rdata_out <= '0;
         endcase
      end else begin
         rdata_out <= '0;
      end
   end

   // ************************************
   // input synchronisers and filters
   // ************************************

   // millisecond prescaler
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         presc_r <= '0;
      end else begin
         presc_r <= ms_tick ? '0 : presc_r + 1'b1;
      end
   end
   assign ms_tick = presc_r == PW'(MS_CYC - 1);

   // two stages per pin, third stage for edges
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         k1_r <= '0;
         k2_r <= '0;
      end else begin
         // RULE_04: base then expansion
         s1_r <= {exp_di_in, base_di_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         k1_r <= key_pin_in;
         k2_r <= k1_r;
      end
   end

   // per input on/off delay counters
   for (genvar i = 0; i < DI_NUM; i++) begin : g_filt
      logic [io_pkg::FILT_W-1:0] cnt_r;
      logic [io_pkg::FILT_W-1:0] on_lim, off_lim, lim;
      // RULE_01: mains delays on first eight
      // RULE_02: standard delays elsewhere
      // RULE_03: slave retention
      assign on_lim = slave ? io_pkg::ON_STD_MS :
         (mains && i < io_pkg::MAINS_DI_NUM) ? io_pkg::ON_MAINS_MS : io_pkg::ON_STD_MS;
      assign off_lim = slave ? io_pkg::RETAIN_MS :
         (mains && i < io_pkg::MAINS_DI_NUM) ? io_pkg::OFF_MAINS_MS : io_pkg::OFF_STD_MS;
      assign lim = s2_r[i] ? on_lim : off_lim;
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            cnt_r <= '0;
            filt_r[i] <= 1'b0;
         end else if (s2_r[i] == filt_r[i]) begin
            cnt_r <= '0;
         end else if (ms_tick) begin
            if (cnt_r + 1'b1 >= lim) begin
               filt_r[i] <= s2_r[i];
               cnt_r <= '0;
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   end

   // fast counters bypass the filter
   for (genvar f = 0; f < io_pkg::FAST_NUM; f++) begin : g_fast
      logic [io_pkg::FAST_W-1:0] fc_r;
      localparam int B = io_pkg::FAST_FIRST + f;
      // RULE_05: dc fast counters
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            fc_r <= '0;
         end else if (dc && s2_r[B] && !s3_r[B]) begin
            fc_r <= fc_r + 1'b1;
         end
      end
      assign fast_cnt_out[f*io_pkg::FAST_W +: io_pkg::FAST_W] = fc_r;
   end

   // ************************************
   // analog channel numbering
   // ************************************

   // RULE_06: aliases stay analog
   // RULE_07: expansion continues numbering
   for (genvar c = 0; c < io_pkg::AI_NUM; c++) begin : g_adc
      localparam int E2 = c - io_pkg::ADC_TWO;
      localparam int E4 = c - io_pkg::AI_LOCAL;
      logic [W-1:0] v2, v4;
      if (c < io_pkg::ADC_TWO) begin : g_lo
         assign v2 = adc_local_in[c*W +: W];
      end else if (E2 < io_pkg::AI_EXP) begin : g_e2
         assign v2 = adc_exp_in[E2*W +: W];
      end else begin : g_z2
         assign v2 = '0;
      end
      if (c < io_pkg::AI_LOCAL) begin : g_l4
         assign v4 = adc_local_in[c*W +: W];
      end else if (E4 < io_pkg::AI_EXP) begin : g_e4
         assign v4 = adc_exp_in[E4*W +: W];
      end else begin : g_z4
         assign v4 = '0;
      end
      assign adc_map[c*W +: W] = adc4 ? v4 : v2;
   end

   // ************************************
   // program cycle phase
   // ************************************

   // idle until first tick, then first cycle, then run
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_r <= io_pkg::PH_IDLE;
      end else begin
         unique case (phase_r)
            io_pkg::PH_IDLE: if (cycle_tick_in) phase_r <= io_pkg::PH_FIRST;
            io_pkg::PH_FIRST: if (cycle_tick_in) phase_r <= io_pkg::PH_RUN;
            io_pkg::PH_RUN: phase_r <= io_pkg::PH_RUN;
         endcase
      end
   end

   // ************************************
   // images taken at cycle start
   // ************************************

   // input, key, analog and network images
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         di_image_r <= '0;
         key_image_out <= '0;
         adc_image_out <= '0;
         net_bit_image_out <= '0;
         net_word_image_out <= '0;
         base_do_out <= '0;
         exp_do_out <= '0;
         net_bit_out <= '0;
         net_word_out <= '0;
      end else if (cycle_tick_in) begin
         // RULE_23: one sample per cycle
         di_image_r <= filt_r;
         // RULE_19: keys only in run
         key_image_out <= run_mode_in ? {k2_r[KN-1 -: io_pkg::KEY_NUM],
            k2_r[io_pkg::KEY_NUM +: io_pkg::KEY_NUM] | k2_r[io_pkg::KEY_NUM-1:0], {io_pkg::KEY_NUM{1'b0}}}
            : '0;
         adc_image_out <= adc_map;
         // RULE_21: network image sizes
         net_bit_image_out <= net_bit_in;
         net_word_image_out <= net_word_in;
         net_bit_out <= prog_nq_in;
         net_word_out <= prog_naq_in;
         // RULE_08: base outputs then expansion
         base_do_out <= prog_do_in[io_pkg::DO_BASE-1:0];
         exp_do_out <= prog_do_in[io_pkg::DO_BASE +: io_pkg::DO_EXP];
      end
   end
   assign di_image_out = di_image_r;

   // ************************************
   // digital flags
   // ************************************

   // network writes; charset needs program presence
   always_comb begin
      net_mask = net_flag_wr_in;
      // RULE_17: charset gate
      net_mask[io_pkg::CHARSET_IDX] = net_flag_wr_in[io_pkg::CHARSET_IDX] & cset_prog;
   end

   // flag inputs collected during the cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_next_r <= '0;
      end else begin
         // RULE_11: flag follows its input
         flag_next_r <= (((flag_next_r & ~prog_flag_wr_in) | (prog_flag_wr_in & prog_flag_val_in))
            & ~net_mask) | (net_mask & net_flag_val_in);
      end
   end

   // RULE_16: image frozen within a cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_img_r <= '0;
      end else if (cycle_tick_in) begin
         flag_img_r <= flag_next_r;
         // RULE_12: startup flag first cycle
         if (phase_r == io_pkg::PH_IDLE) begin
            flag_img_r[io_pkg::STARTUP_IDX] <= 1'b1;
         end
      end
   end
   assign flag_out = flag_img_r;

   // blank outputs have no storage and no read path
   // RULE_09: blanks drive nothing

   // ************************************
   // display selection
   // ************************************

   function automatic logic [1:0] color_of(input logic wh, input logic am, input logic rd);
      color_of = rd ? 2'(io_pkg::COL_RED) : am ? 2'(io_pkg::COL_AMBER) :
         wh ? 2'(io_pkg::COL_WHITE) : 2'(io_pkg::COL_OFF);
   endfunction

   // RULE_13: separate base and panel colours
   assign base_color_out = color_of(flag_img_r[io_pkg::WHITE_BASE_IDX],
      flag_img_r[io_pkg::AMBER_BASE_IDX], flag_img_r[io_pkg::RED_BASE_IDX]);
   assign panel_color_out = color_of(flag_img_r[io_pkg::WHITE_PANEL_IDX],
      flag_img_r[io_pkg::AMBER_PANEL_IDX], flag_img_r[io_pkg::RED_PANEL_IDX]);

   // RULE_14: flag picks the set
   // RULE_15: fall back to setting
   assign charset_sel_out = cset_prog ? flag_img_r[io_pkg::CHARSET_IDX] : ctrl_r[io_pkg::CTL_CSET];

   // ************************************
   // analog markers, dac, shift bits
   // ************************************

   // RULE_11: marker store with cycle image
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int m = 0; m < io_pkg::AM_NUM; m++) begin
            am_next_r[m] <= '0;
            am_img_r[m] <= '0;
         end
         am_rdata_out <= '0;
      end else begin
         if (am_wr_in) begin
            am_next_r[am_idx_in] <= am_wdata_in;
         end
         if (cycle_tick_in) begin
            am_img_r <= am_next_r;
         end
         am_rdata_out <= am_img_r[am_rd_idx_in];
      end
   end

   // RULE_10: only analog sources drive dacs
   for (genvar q = 0; q < io_pkg::AQ_NUM; q++) begin : g_dac
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            dac_out[q*W +: W] <= '0;
         end else if (dac_wr_in[q] && dac_kind_in != io_pkg::SRC_OTHER) begin
            dac_out[q*W +: W] <= dac_wdata_in;
         end
      end
   end

   // sticky refusal flag, set wins over clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dac_err_r <= 1'b0;
      end else if (dac_wr_in != '0 && dac_kind_in == io_pkg::SRC_OTHER) begin
         dac_err_r <= 1'b1;
      end else if (wr_in && addr_in == io_pkg::REG_STATUS && wdata_in[io_pkg::ST_DAC_ERR]) begin
         dac_err_r <= 1'b0;
      end
   end

   // RULE_18: shift function only
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_bits_out <= '0;
      end else if (shift_load_in) begin
         shift_bits_out <= shift_val_in;
      end
   end

   // RULE_20: fixed levels
   assign const_one_out = 1'b1;
   assign const_zero_out = 1'b0;

   // RULE_22: parameter edits only
   assign edit_grant_out = edit_req_in && (edit_is_par_in || !net_prog);

   // ************************************
   // assertions
   // ************************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_FILT_ON_TICK: assert property ($changed(filt_r) |-> $past(ms_tick)) // RULE_02
      else $error("filter changed off the millisecond tick");
   AST_FILT_STD_ON: assert property (!mains && !slave && !$past(filt_r[8]) && s2_r[8]
      && $stable(s2_r[8]) [*8] |-> !filt_r[8] || $past(ms_tick)) // RULE_02
      else $error("filter took a level without a tick");
   AST_IMAGE_HOLD: assert property (!$past(cycle_tick_in) |-> $stable(di_image_r)) // RULE_23
      else $error("input image moved inside a cycle");
   AST_FLAG_HOLD: assert property (!$past(cycle_tick_in) |-> $stable(flag_img_r)) // RULE_16
      else $error("flag image moved inside a cycle");
   AST_STARTUP: assert property (phase_r == io_pkg::PH_FIRST |-> flag_img_r[io_pkg::STARTUP_IDX]) // RULE_12
      else $error("startup flag low in first cycle");
   AST_CHARSET: assert property (!cset_prog |-> charset_sel_out == ctrl_r[io_pkg::CTL_CSET]) // RULE_15
      else $error("charset not from setting");
   AST_NET_EDIT: assert property (net_prog && edit_req_in && !edit_is_par_in |-> !edit_grant_out) // RULE_22
      else $error("program edit granted with network io");
   AST_DAC_REFUSE: assert property (dac_wr_in != '0 && dac_kind_in == io_pkg::SRC_OTHER
      |=> $stable(dac_out) && dac_err_r) // RULE_10
      else $error("dac took an illegal source");
   AST_SHIFT_RO: assert property (!$past(shift_load_in) |-> $stable(shift_bits_out)) // RULE_18
      else $error("shift bits changed without the shift function");
   AST_KEYS_OFF: assert property ($past(cycle_tick_in) && !$past(run_mode_in) |-> key_image_out == '0) // RULE_19
      else $error("keys active outside run");

   COV_FIRST_CYCLE: cover property (phase_r == io_pkg::PH_FIRST ##1 phase_r == io_pkg::PH_RUN);
   COV_FILT_RISE: cover property ($rose(filt_r[0]));
   COV_DAC_REFUSE: cover property (dac_wr_in != '0 && dac_kind_in == io_pkg::SRC_OTHER);
   COV_NET_CSET: cover property (net_flag_wr_in[io_pkg::CHARSET_IDX] && cset_prog);
endmodule

// *** tb/field_model.sv ***
`timescale 1ns/10ps
// ****
// field switch contacts
// ****
module field_model (
   // clock and wanted level
   input wire logic clk_in,
   input wire logic lvl_in,
   // contacts to base and expansion terminals
   output logic [7:0] base_di_out = 8'h00,
   output logic [15:0] exp_di_out = 16'h0000
);
   // contacts move late after the edge, not aligned to it
   always @(posedge clk_in) begin
      base_di_out <= #7 {7'h00, lvl_in};
      exp_di_out <= #7 {15'h0000, lvl_in};
   end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
   // ****
   // signals and instances
   // ****
   logic ref_clk_in = 0, rst_n_in, wr_in, rd_in, cycle_tick_in, run_mode_in, am_wr_in, shift_load_in, lvl = 0;
   logic edit_req_in, edit_is_par_in, edit_grant_out, const_one_out, const_zero_out, charset_sel_out;
   logic [1:0] dac_kind_in, base_color_out, panel_color_out;
   logic [3:0] addr_in, base_do_out;
   logic [5:0] am_idx_in, am_rd_idx_in;
   logic [7:0] dac_wr_in, base_di_in;
   logic [11:0] key_pin_in, key_image_out;
   logic [15:0] exp_di_in, am_wdata_in, dac_wdata_in, am_rdata_out, exp_do_out;
   logic [19:0] prog_do_in;
   logic [23:0] di_image_out;
   logic [31:0] wdata_in, rdata_out, shift_val_in, shift_bits_out, d;
   logic [63:0] adc_local_in, adc_exp_in, prog_flag_wr_in, prog_flag_val_in, prog_nq_in, net_flag_wr_in;
   logic [63:0] net_flag_val_in, net_bit_in, fast_cnt_out, flag_out, net_bit_image_out, net_bit_out;
   logic [127:0] adc_image_out, dac_out;
   logic [255:0] prog_naq_in, net_word_out;
   logic [511:0] net_word_in, net_word_image_out;
   int err_count = 0, n_compared = 0, cyc = 0;
   io_image_flags #(.MS_CYC(4)) dut (.*);
   field_model fm (.clk_in(ref_clk_in), .lvl_in(lvl), .base_di_out(base_di_in), .exp_di_out(exp_di_in));
   // clock and hang limit
   always #20 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // register write, one strobe cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'h1;
      @(posedge ref_clk_in);
      wr_in <= 1'h0;
   endtask
   // register read, data stands one cycle then idles at zero
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'h1;
      @(posedge ref_clk_in);
      rd_in <= 1'h0;
      #1 d = rdata_out;
      @(posedge ref_clk_in);
      #1 chk("rd_idle", rdata_out, 0);
   endtask
   // one program cycle start pulse
   task automatic tick();
      @(posedge ref_clk_in);
      cycle_tick_in <= 1'h1;
      @(posedge ref_clk_in);
      cycle_tick_in <= 1'h0;
      #1;
   endtask
   // level held just short of, then well past, the delay
   task automatic filt(input logic [31:0] c, input logic l, input int lim);
      wr(io_pkg::REG_CTRL, c);
      lvl <= l;
      clk((lim - 1) * 4 - 4);
      tick();
      rd(io_pkg::REG_DI);
      chk("di_early", d[0], !l);
      clk(12);
      tick();
      rd(io_pkg::REG_DI);
      chk("di_late", d[0], l);
      chk("di_exp", di_image_out[8], l);
   endtask
   // ****
   // test sequence
   // ****
   initial begin
      {wr_in, rd_in, cycle_tick_in, run_mode_in, am_wr_in, shift_load_in, edit_req_in, edit_is_par_in} = '0;
      {dac_kind_in, addr_in, am_idx_in, am_rd_idx_in, dac_wr_in, key_pin_in, am_wdata_in, dac_wdata_in} = '0;
      {prog_do_in, wdata_in, shift_val_in, adc_local_in, adc_exp_in, prog_flag_wr_in, prog_flag_val_in} = '0;
      {prog_nq_in, net_flag_wr_in, net_flag_val_in, net_bit_in, prog_naq_in, net_word_in} = '0;
      rst_n_in = 1'h0;
      clk(4);
      rst_n_in <= 1'h1;
      #1 chk("levels", {const_one_out, const_zero_out}, 2'h2);
      tick();
      chk("startup", flag_out[7], 1);
      tick();
      chk("startup_end", flag_out[7], 0);
      rd(4'hF);
      chk("unmapped", d, 0);
      filt(32'h0, 1, 5);
      filt(32'h0, 0, 5);
      filt(32'h1 << io_pkg::CTL_MAINS, 1, 25);
      filt(32'h1 << io_pkg::CTL_MAINS, 0, 20);
      filt(32'h1 << io_pkg::CTL_SLAVE, 1, 5);
      filt(32'h1 << io_pkg::CTL_SLAVE, 0, 100);
      wr(io_pkg::REG_CTRL, 32'h1 << io_pkg::CTL_CSET);
      @(posedge ref_clk_in);
      prog_flag_wr_in <= 64'h0000_0000_1100_0008;
      prog_flag_val_in <= 64'h0000_0000_1100_0008;
      net_flag_wr_in <= 64'h0000_0000_0600_0000;
      net_flag_val_in <= 64'h0000_0000_0600_0000;
      clk(2);
      #1 chk("flag_wait", flag_out[3], 0);
      tick();
      chk("flag", flag_out[3], 1);
      chk("base_col", base_color_out, 2'h3);
      chk("panel_col", panel_color_out, 2'h1);
      chk("cset_net", flag_out[26], 0);
      chk("cset_cfg", charset_sel_out, 1);
      wr(io_pkg::REG_CTRL, 32'h1 << io_pkg::CTL_CSET_PROG);
      tick();
      chk("cset_one", charset_sel_out, 1);
      net_flag_val_in <= 64'h0;
      tick();
      chk("cset_zero", charset_sel_out, 0);
      @(posedge ref_clk_in);
      dac_wr_in <= 8'h01;
      dac_kind_in <= io_pkg::SRC_MARKER;
      dac_wdata_in <= 16'h1234;
      am_wr_in <= 1'h1;
      am_idx_in <= 6'h05;
      am_rd_idx_in <= 6'h05;
      am_wdata_in <= 16'h5A5A;
      adc_local_in <= 64'h4444_3333_2222_1111;
      adc_exp_in <= 64'h8888_7777_6666_5555;
      @(posedge ref_clk_in);
      am_wr_in <= 1'h0;
      dac_kind_in <= io_pkg::SRC_OTHER;
      dac_wdata_in <= 16'hBEEF;
      shift_load_in <= 1'h1;
      shift_val_in <= 32'hA5C3_0F96;
      run_mode_in <= 1'h1;
      key_pin_in <= 12'h281;
      prog_do_in <= 20'hABCDE;
      net_bit_in <= 64'h0123_4567_89AB_CDEF;
      @(posedge ref_clk_in);
      dac_wr_in <= 8'h00;
      shift_load_in <= 1'h0;
      #1 chk("dac", dac_out[15:0], 16'h1234);
      chk("shift", shift_bits_out, 32'hA5C3_0F96);
      rd(io_pkg::REG_STATUS);
      chk("dac_err", d[io_pkg::ST_DAC_ERR], 1);
      tick();
      chk("keys", key_image_out, 12'h290);
      chk("do", {exp_do_out, base_do_out}, 20'hABCDE);
      chk("net_in", net_bit_image_out, 64'h0123_4567_89AB_CDEF);
      chk("adc_lo", adc_image_out[63:0], 64'h6666_5555_2222_1111);
      chk("adc_hi", adc_image_out[127:64], 64'h0000_0000_8888_7777);
      wr(io_pkg::REG_CTRL, 32'h1 << io_pkg::CTL_NET_PROG);
      chk("marker", am_rdata_out, 16'h5A5A);
      @(posedge ref_clk_in);
      edit_req_in <= 1'h1;
      #1 chk("edit_deny", edit_grant_out, 0);
      @(posedge ref_clk_in);
      edit_is_par_in <= 1'h1;
      #1 chk("edit_par", edit_grant_out, 1);
      end_sim();
   end
endmodule
